// [pkg/comp_evt_pkg.sv]
// Constants shared by the comparator event logic and its synchroniser.
// Assumes a 32-bit APB3 register bus and three comparators on one clock.
package comp_evt_pkg;

    // Number of comparators served by this block
    localparam int NUM_COMP = 3;

    // APB address width and register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_RAW_STATUS = 8'h00;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
    localparam logic [7:0] OFS_MASKED_STATUS = 8'h08;
    localparam logic [7:0] OFS_OUTPUT_VALUE = 8'h0C;
    localparam logic [7:0] OFS_CTRL_BASE = 8'h10;
    localparam logic [7:0] OFS_CTRL_STEP = 8'h04;

    // Per-comparator control word layout
    localparam int CTRL_W = 16;
    localparam int CTRL_TRIG_LSB = 0;
    localparam int CTRL_INT_LSB = 4;
    localparam int CTRL_REF_LSB = 8;
    localparam int CTRL_OUT_EN_BIT = 12;
    localparam int CTRL_OUT_INV_BIT = 13;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [NUM_COMP-1:0] RAW_RESET = 3'h0;
    localparam logic [NUM_COMP-1:0] ENABLE_RESET = 3'h0;

    // Condition codes, shared by the trigger and interrupt selectors
    localparam logic [2:0] adc_trigger_off = 3'h0;
    localparam logic [2:0] adc_trigger_level_high = 3'h1;
    localparam logic [2:0] adc_trigger_level_low = 3'h2;
    localparam logic [2:0] adc_trigger_falling = 3'h3;
    localparam logic [2:0] adc_trigger_rising = 3'h4;
    localparam logic [2:0] adc_trigger_any_edge = 3'h5;

    // Reference source codes
    localparam logic [1:0] ref_own_pin = 2'h0;
    localparam logic [1:0] ref_shared_pin_zero = 2'h1;
    localparam logic [1:0] ref_internal_voltage = 2'h2;

endpackage

// [design/comp_level_sync.sv]
// Two-stage synchroniser and edge finder for the comparator outputs.
// Assumes the comparator outputs are asynchronous to CLK_IN.
`timescale 1ns/100ps
`default_nettype none

module comp_level_sync (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Asynchronous comparator outputs
    input wire logic [comp_evt_pkg::NUM_COMP-1:0] RAW_IN,
    // Synchronised level and edges
    output logic [comp_evt_pkg::NUM_COMP-1:0] LEVEL_OUT,
    output logic [comp_evt_pkg::NUM_COMP-1:0] RISE_OUT,
    output logic [comp_evt_pkg::NUM_COMP-1:0] FALL_OUT
);
    import comp_evt_pkg::*;

    typedef struct packed {
        logic [NUM_COMP-1:0] meta;
        logic [NUM_COMP-1:0] stable;
        logic [NUM_COMP-1:0] prev;
    } sync_t;

    sync_t r;
    sync_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // Meta stage feeds only the stable stage
    always_comb begin
        next_r = r;
        next_r.meta = RAW_IN;
        next_r.stable = r.meta;
        next_r.prev = r.stable;
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edges compare the two settled stages only
    assign LEVEL_OUT = r.stable;
    assign RISE_OUT = r.stable & ~r.prev;
    assign FALL_OUT = ~r.stable & r.prev;

endmodule // comp_level_sync

`default_nettype wire

// [design/comp_event_logic.sv]
// Control, interrupt and converter-trigger logic around the comparators.
// Assumes an APB3 master on CLK_IN, asynchronous comparator outputs,
// and an interrupt controller that samples IRQ_OUT as a level.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Interrupt and converter trigger detection are separate, each with its own selector.
// - Trigger selector: off, high, low, falling, rising or any edge.
// - Interrupt selector: off, high, low, falling, rising or any edge.
// - Reference is own pin, shared pin of comparator zero, or internal voltage.
// - Result may drive a pin, straight or inverted, by configuration.
// - Writing one to a raw status bit clears that interrupt request.
// - A level condition still holding keeps its interrupt pending despite clears.
// - Per-comparator enable gates the pending interrupt onto the processor line.
// - Software reads raw status and enable-gated masked status.
// - A status bit per comparator reads its present output level.
module comp_event_logic (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic [comp_evt_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Analog side
    input wire logic [comp_evt_pkg::NUM_COMP-1:0] COMP_RAW_IN,
    output logic [2*comp_evt_pkg::NUM_COMP-1:0] REF_SEL_OUT,
    // Result pins
    output logic [comp_evt_pkg::NUM_COMP-1:0] PIN_OUT,
    output logic [comp_evt_pkg::NUM_COMP-1:0] PIN_OE_OUT,
    // Converter trigger and interrupt
    output logic [comp_evt_pkg::NUM_COMP-1:0] ADC_TRIG_OUT,
    output logic IRQ_OUT
);
    import comp_evt_pkg::*;

    typedef logic [CTRL_W-1:0] ctrl_word_t;

    typedef struct packed {
        ctrl_word_t [NUM_COMP-1:0] ctrl;
        logic [NUM_COMP-1:0] raw;
        logic [NUM_COMP-1:0] enable;
        logic [NUM_COMP-1:0] trig;
        logic [NUM_COMP-1:0] pin;
        logic [2*NUM_COMP-1:0] ref_sel;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    state_t r;
    state_t next_r;

    logic [NUM_COMP-1:0] level;
    logic [NUM_COMP-1:0] rise;
    logic [NUM_COMP-1:0] fall;
    logic [NUM_COMP-1:0] int_hit;
    logic [NUM_COMP-1:0] trig_hit;
    logic setup_phase;
    logic write_access;

    ////////////////////////////////////////////////////////////////////////
    // Shared condition decoder: one table serves both paths
    function automatic logic cond_hit(
        input logic [2:0] sel,
        input logic lvl,
        input logic up,
        input logic down
    );
        logic hit;
        hit = 1'b0;
        case (sel)
            adc_trigger_level_high: hit = lvl;
            adc_trigger_level_low: hit = ~lvl;
            adc_trigger_falling: hit = down;
            adc_trigger_rising: hit = up;
            adc_trigger_any_edge: hit = up | down;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Byte address of the control word of comparator idx
    function automatic logic [7:0] ctrl_addr(input int idx);
        logic [7:0] step;
        step = OFS_CTRL_STEP * 8'(idx);
        return OFS_CTRL_BASE + step;
    endfunction

    // Reserved reference code falls back to the comparator's own pin
    function automatic logic [1:0] ref_decode(input logic [1:0] code);
        logic [1:0] sel;
        sel = ref_own_pin;
        case (code)
            ref_shared_pin_zero: sel = ref_shared_pin_zero;
            ref_internal_voltage: sel = ref_internal_voltage;
            default: sel = ref_own_pin;
        endcase
        return sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronise comparator outputs before any detection
    comp_level_sync sync_u (
        .CLK_IN(CLK_IN),
        .RESET_IN(RESET_IN),
        .RAW_IN(COMP_RAW_IN),
        .LEVEL_OUT(level),
        .RISE_OUT(rise),
        .FALL_OUT(fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two independent detectors per comparator
    always_comb begin
        int_hit = '0;
        trig_hit = '0;
        for (int i = 0; i < NUM_COMP; i++) begin
            // Interrupt selector field
            int_hit[i] = cond_hit(r.ctrl[i][CTRL_INT_LSB +: 3],
                level[i], rise[i], fall[i]);
            // Trigger selector field, a separate decode
            trig_hit[i] = cond_hit(r.ctrl[i][CTRL_TRIG_LSB +: 3],
                level[i], rise[i], fall[i]);
        end
    end

    // Bus phase decode
    assign setup_phase = PSEL_IN & ~PENABLE_IN;
    assign write_access = PSEL_IN & PENABLE_IN & PWRITE_IN;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, status and outputs
    always_comb begin
        next_r = r;

        // Read data and error are captured in the setup cycle so the
        // access cycle can answer at once from flip-flops.
        if (setup_phase) begin
            next_r.rdata = 32'h0000_0000;
            next_r.slverr = 1'b0;
            case (PADDR_IN)
                OFS_RAW_STATUS: begin
                    next_r.rdata[NUM_COMP-1:0] = r.raw;
                end
                OFS_INT_ENABLE: begin
                    next_r.rdata[NUM_COMP-1:0] = r.enable;
                end
                OFS_MASKED_STATUS: begin
                    next_r.rdata[NUM_COMP-1:0] = r.raw & r.enable;
                end
                OFS_OUTPUT_VALUE: begin
                    next_r.rdata[NUM_COMP-1:0] = level;
                end
                default: begin
                    next_r.slverr = 1'b1;
                    for (int i = 0; i < NUM_COMP; i++) begin
                        if (PADDR_IN == ctrl_addr(i)) begin
                            next_r.rdata[CTRL_W-1:0] = r.ctrl[i];
                            next_r.slverr = 1'b0;
                        end
                    end
                end
            endcase
        end

        // Register writes land on the access edge only
        if (write_access) begin
            if (PADDR_IN == OFS_INT_ENABLE) begin
                next_r.enable = PWDATA_IN[NUM_COMP-1:0];
            end
            for (int i = 0; i < NUM_COMP; i++) begin
                if (PADDR_IN == ctrl_addr(i)) begin
                    next_r.ctrl[i] = PWDATA_IN[CTRL_W-1:0];
                end
            end
        end

        // Sticky status: a fresh hit wins over a write-one clear, and a
        // level condition re-sets the bit every cycle it holds.
        for (int i = 0; i < NUM_COMP; i++) begin
            if (write_access && PADDR_IN == OFS_RAW_STATUS && PWDATA_IN[i]) begin
                next_r.raw[i] = 1'b0;
            end
            if (int_hit[i]) begin
                next_r.raw[i] = 1'b1;
            end
        end

        // Trigger follows the selected condition with one cycle of delay;
        // edge choices give a one-cycle pulse, level choices a level.
        next_r.trig = trig_hit;

        // Result pin and reference select, each from its control word
        for (int i = 0; i < NUM_COMP; i++) begin
            next_r.pin[i] = level[i] ^ r.ctrl[i][CTRL_OUT_INV_BIT];
            next_r.ref_sel[2*i +: 2] = ref_decode(r.ctrl[i][CTRL_REF_LSB +: 2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            r.ctrl <= {NUM_COMP{CTRL_RESET}};
            r.raw <= RAW_RESET;
            r.enable <= ENABLE_RESET;
            r.trig <= '0;
            r.pin <= '0;
            r.ref_sel <= '0;
            r.rdata <= 32'h0000_0000;
            r.slverr <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Zero wait states: every access completes in its first access cycle
    assign PREADY_OUT = 1'b1;
    assign PRDATA_OUT = r.rdata;
    assign PSLVERR_OUT = r.slverr & PSEL_IN & PENABLE_IN;
    assign REF_SEL_OUT = r.ref_sel;
    assign ADC_TRIG_OUT = r.trig;
    assign PIN_OUT = r.pin;

    // Pin is driven only while its output is switched on
    always_comb begin
        for (int i = 0; i < NUM_COMP; i++) begin
            PIN_OE_OUT[i] = r.ctrl[i][CTRL_OUT_EN_BIT];
        end
    end

    // Level line, held while any enabled status bit stands; software
    // clears early because its write can land cycles late
    assign IRQ_OUT = |(r.raw & r.enable);

endmodule // comp_event_logic

`default_nettype wire

// [tb/comp_evt_props.sv]
// Port-level checker for the comparator event block.
// Assumes one clock domain and the package register map.
`timescale 1ns/100ps
`default_nettype none

module comp_evt_props
    import comp_evt_pkg::*;
(
    // Clock, reset and bus
    input wire logic CLK_IN, RESET_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN, PRDATA_OUT,
    input wire logic PREADY_OUT, PSLVERR_OUT, IRQ_OUT,
    // Comparator side
    input wire logic [2:0] COMP_RAW_IN, PIN_OUT, PIN_OE_OUT, ADC_TRIG_OUT,
    input wire logic [5:0] REF_SEL_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    // Write access edge
    wire wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;

    ////////////////////////////////////////
    pready_a: assert property (PREADY_OUT) else $error("pready low");
    err_map_a: assert property (PSEL_IN && PENABLE_IN && PADDR_IN[1:0] == 2'h0
        |-> PSLVERR_OUT == (PADDR_IN > 8'h18)) else $error("slave error wrong");
    rst_quiet_a: assert property ($past(RESET_IN)
        |-> !IRQ_OUT && ADC_TRIG_OUT == 3'h0 && PIN_OE_OUT == 3'h0) else $error("not idle");
    mask_off_a: assert property (wr_acc && PADDR_IN == OFS_INT_ENABLE
        && PWDATA_IN[2:0] == 3'h0 |=> !IRQ_OUT) else $error("masked irq seen");
    ref_sel_a: assert property (wr_acc && PADDR_IN == 8'h18 && PWDATA_IN[9:8] != 2'h3
        |=> ##1 REF_SEL_OUT[5:4] == $past(PWDATA_IN[9:8], 2)) else $error("ref select wrong");
    pin_oe_a: assert property (wr_acc && PADDR_IN == 8'h18
        |=> PIN_OE_OUT[2] == $past(PWDATA_IN[12])) else $error("pin enable wrong");
    trig_off_a: assert property (wr_acc && PADDR_IN == 8'h18 && PWDATA_IN[2:0] == 3'h0
        |-> ##2 !ADC_TRIG_OUT[2]) else $error("trigger while off");
    masked_irq_a: assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN
        && PADDR_IN == OFS_MASKED_STATUS |=> PRDATA_OUT[31:3] == 29'h0
        && (PRDATA_OUT[2:0] != 3'h0) == $past(IRQ_OUT)) else $error("masked vs irq");
    // Five quiet samples are needed: the two-stage sync refills after reset
    pin_sync_a: assert property (($stable(COMP_RAW_IN) && !PSEL_IN) [*5]
        |-> $stable(PIN_OUT)) else $error("pin moved without cause");

    // Main scenarios
    cover property (IRQ_OUT);
    cover property ($rose(ADC_TRIG_OUT[1]));
    cover property (PSLVERR_OUT);
endmodule // comp_evt_props

bind comp_event_logic comp_evt_props comp_evt_props_i (.*);
`default_nettype wire

// [tb/comp_far_side.sv]
// Far side model: interrupt controller and converter sequencer.
// Assumes both sample the block outputs on the system clock.
`timescale 1ns/100ps
`default_nettype none

module comp_far_side (
    // Clock and count clear
    input wire logic clk_in,
    input wire logic clr_in,
    // Block outputs
    input wire logic [2:0] trig_in,
    input wire logic irq_in,
    // Observations
    output logic [2:0][7:0] trig_cnt_out,
    output logic irq_seen_out
);
    // One capture per cycle of trigger; counts saturate to stay meaningful
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 3; i++) begin
            if (clr_in) begin
                trig_cnt_out[i] <= 8'h00;
            end else if (trig_in[i] && trig_cnt_out[i] != 8'hFF) begin
                trig_cnt_out[i] <= trig_cnt_out[i] + 8'h01;
            end
        end
        irq_seen_out <= !clr_in && (irq_seen_out || irq_in); // Handler entry
    end
endmodule // comp_far_side
`default_nettype wire

// [tb/comparator_event_logic_tb.sv]
// Self-checking bench for the comparator event block.
// Assumes a 50 MHz clock and zero-wait APB answers.
`timescale 1ns/100ps
`default_nettype none

module comparator_event_logic_tb;
    import comp_evt_pkg::*;
    typedef struct packed {
        logic [1:0] idx;
        logic [2:0] icode;
        logic [2:0] tcode;
        logic start;
        logic raw;
        logic [1:0] trig;
    } row_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b1;
    logic [7:0] pa = 8'h00;
    logic [31:0] pd = 32'h0, prd, rdat;
    logic pready, perr, rerr, irq, seen;
    logic [2:0] craw = 3'h0, pin, oe, trig;
    logic [5:0] rsel;
    logic [2:0][7:0] cnt;
    int num_errors = 0, samples_checked = 0;
    // Trig column: 0 none, 1 one pulse, 2 held
    row_t rows [7] = '{'{2'h0, 3'h4, 3'h3, 1'h0, 1'h1, 2'h0},
        '{2'h1, 3'h3, 3'h4, 1'h0, 1'h0, 2'h1}, '{2'h2, 3'h5, 3'h5, 1'h1, 1'h1, 2'h1},
        '{2'h0, 3'h1, 3'h1, 1'h0, 1'h1, 2'h2}, '{2'h1, 3'h2, 3'h0, 1'h1, 1'h1, 2'h0},
        '{2'h2, 3'h0, 3'h2, 1'h1, 1'h0, 2'h2}, '{2'h0, 3'h3, 3'h4, 1'h1, 1'h1, 2'h0}};

    comp_event_logic comp_event_logic_i (.CLK_IN(clk), .RESET_IN(rst), .PADDR_IN(pa),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pd), .PRDATA_OUT(prd),
        .PREADY_OUT(pready), .PSLVERR_OUT(perr), .COMP_RAW_IN(craw), .REF_SEL_OUT(rsel),
        .PIN_OUT(pin), .PIN_OE_OUT(oe), .ADC_TRIG_OUT(trig), .IRQ_OUT(irq));
    comp_far_side comp_far_side_i (.clk_in(clk), .clr_in(clr), .trig_in(trig),
        .irq_in(irq), .trig_cnt_out(cnt), .irq_seen_out(seen));

    ////////////////////////////////////////
    // Clock and watchdog
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // One APB transfer; answer taken at the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        tick(6);
        rst <= 1'b0;
        clr <= 1'b0;
        tick(3);
        // Each row: settle, configure, clear, fire one transition
        foreach (rows[k]) begin
            craw[rows[k].idx] <= rows[k].start;
            tick(6);
            apb(1'b1, {4'h1, rows[k].idx, 2'h0}, {rows[k].icode, 1'b0, rows[k].tcode});
            apb(1'b1, OFS_RAW_STATUS, 32'h7);
            clr <= 1'b1;
            craw[rows[k].idx] <= !rows[k].start;
            tick(1);
            clr <= 1'b0;
            tick(8);
            apb(1'b0, OFS_RAW_STATUS, 32'h0);
            @(negedge clk);
            chk(rdat[rows[k].idx], rows[k].raw);
            chk(cnt[rows[k].idx] > 8'h01 ? 8'h02 : cnt[rows[k].idx], rows[k].trig);
        end
        // Level interrupt on comparator one: masked, then cleared
        apb(1'b1, 8'h14, 32'h10);
        apb(1'b1, OFS_INT_ENABLE, 32'h0);
        apb(1'b1, OFS_RAW_STATUS, 32'h7);
        clr <= 1'b1;
        craw[1] <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(6);
        apb(1'b0, OFS_MASKED_STATUS, 32'h0);
        chk({seen, irq, rdat[29:0]}, 32'h0);
        apb(1'b0, OFS_RAW_STATUS, 32'h0);
        chk(rdat, 32'h2);
        apb(1'b1, OFS_INT_ENABLE, 32'h2);
        apb(1'b0, OFS_MASKED_STATUS, 32'h0);
        chk({rdat[30:0], irq}, 32'h5);
        // Clear issued first thing in the handler, level still true
        apb(1'b1, OFS_RAW_STATUS, 32'h2);
        apb(1'b0, OFS_RAW_STATUS, 32'h0);
        chk(rdat, 32'h2);
        craw[1] <= 1'b0;
        tick(6);
        apb(1'b1, OFS_RAW_STATUS, 32'h2);
        @(negedge clk);
        chk(irq, 1'b0);
        chk(seen, 1'b1);
        // Reference codes, pin drive and live value on comparator two
        for (int v = 0; v < 6; v++) begin
            @(posedge clk);
            craw[2] <= v[0];
            tick(5);
            apb(1'b1, 8'h18, {18'h0, v[0], 1'b1, 2'h0, 2'(v >> 1), 8'h0});
            // Reference and pin registers follow the control word one edge later
            tick(1);
            @(negedge clk);
            chk({rsel[5:4], oe[2], pin[2]}, {2'(v >> 1), 2'h2});
            apb(1'b0, OFS_OUTPUT_VALUE, 32'h0);
            chk(rdat[2], v[0]);
        end
        // Unmapped read answers with an error and zero data
        apb(1'b0, 8'h1C, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
        // Second reset in mid-run returns everything to zero
        craw <= 3'h0;
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        @(negedge clk);
        chk({irq, trig, oe, rsel, pin}, 32'h0);
        for (int a = 0; a < 28; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rdat, 32'h0);
        end
        wrap_up();
    end
endmodule // comparator_event_logic_tb
`default_nettype wire
